//--- design/cs_range_match.v
// one chip-select range comparator
// assumes base and limit are stable during the cycle being decoded
`include "ext_bus_consts.vh"
module cs_range_match
#(
    parameter AW = 24
)
(
    input wire [AW-1:0] addr,
    input wire [AW-1:0] base,
    input wire [AW-1:0] limit,
    output wire hit
);
    // inclusive range compare
    assign hit = (addr >= base) && (addr <= limit);
endmodule

//--- design/ext_bus_consts.vh
// constants for the external bus select and strobe logic
// assumes inclusion by bare name from design modules only
`ifndef EXT_BUS_CONSTS_VH
`define EXT_BUS_CONSTS_VH
// field position of the high-byte pin select in chip config reg zero
`define HIGH_BYTE_PIN_SELECT_POS 2
// field position of the hold protocol enable in the window register
`define HOLD_PROTOCOL_ENABLE_POS 7
// number of chip selects
`define NUM_CHIP_SELECTS 6
// internal address width
`define INT_ADDR_W 24
// external address width
`define EXT_ADDR_W 20
// reset range of chip select zero (internal addressing)
`define CS0_RESET_BASE 24'hFF2000
`define CS0_RESET_LIMIT 24'hFF20FF
// partition steered by external access
`define EA_PART_LOW 24'hFF2000
`define EA_PART_HIGH 24'hFFDFFF
// reset value of chip config reg zero: byte-high-enable selected
`define CHIP_CONFIG_REG_ZERO_RESET 8'h04
// reset value of bus configuration word of each chip select
`define BUS_CFG_RESET 8'h00
`endif

//--- design/ext_bus_strobes.v
// external bus select and strobe logic: byte lanes, chip selects,
// bus request, divided clock and internal/external routing
// assumes the bus controller presents one access at a time, held stable
// for the cycle it marks with CYCLE_START
// assumes bus width and wait states travel in the opaque bus config word;
// this block only forwards that word and counts no wait states itself
// assumes the external access level is settled at the start edge, since a
// level that moves in that cycle steers the access as it stands then
// assumes port writes arrive as one-cycle pulses on PORT_WE
//
// How it works
// - on 16-bit cycles the byte-high-enable goes low for word and high-byte accesses.
// - byte-high-enable with address bit zero codes lanes 00 both, 01 high, 10 low.
// - bit two of chip config reg zero picks byte-high-enable at 1, write-high at 0.
// - bus request goes low during a hold while an external cycle is pending.
// - while hold protocol enable is set the shared pin is only bus request.
// - port writes to that pin are ignored until hold protocol enable clears.
// - the clock output runs at half the internal clock with 50 percent duty.
// - each of the six selects goes low on an external cycle when the internal address is in its range and in no lower select's range.
// - an address in no range asserts no select and uses select five's bus setup.
// - after reset select zero covers FF2000 to FF20FF, F2000 to F20FF outside.
// - the FF2000 to FFDFFF partition goes internal unless external access is low.
// - external access is never latched; its present level steers every access in that partition.
`include "ext_bus_consts.vh"
module ext_bus_strobes
#(
    parameter NCS = 6,
    parameter AW = 24,
    parameter CFGW = 8
)
(
    input wire CLOCK,
    input wire RST_N,
    // access request from the bus controller
    input wire CYCLE_START,
    input wire CYCLE_WRITE,
    input wire CYCLE_WORD,
    input wire [AW-1:0] CYCLE_ADDR,
    input wire EXTERNAL_ACCESS_N,
    // chip config reg zero write
    input wire CHIP_CONFIG_REG_ZERO_WE,
    input wire [7:0] CHIP_CONFIG_REG_ZERO_WDATA,
    // chip select range programming
    input wire CS_WE,
    input wire [2:0] CS_INDEX,
    input wire [AW-1:0] CS_BASE,
    input wire [AW-1:0] CS_LIMIT,
    input wire [CFGW-1:0] CS_BUS_CFG,
    // hold handling
    input wire HOLD_PROTOCOL_ENABLE_BIT,
    input wire HOLD_ACTIVE,
    // port two writes for the shared pin
    input wire PORT_WE,
    input wire PORT_TWO_MODE_REG,
    input wire PORT_TWO_DIRECTION_REG,
    input wire PORT_TWO_OUTPUT_REG,
    // outputs
    output reg BYTE_HIGH_ENABLE_N,
    output reg WRITE_HIGH_STROBE_N,
    output reg ADDRESS_BIT_ZERO,
    output reg [NCS-1:0] CHIP_SELECT_LINES_N,
    output reg [CFGW-1:0] ACTIVE_BUS_CFG,
    output reg [`EXT_ADDR_W-1:0] EXT_ADDR,
    output reg EXTERNAL_CYCLE,
    output reg BUS_REQUEST_OUT_N,
    output reg PIN_IS_PORT,
    output reg PIN_PORT_OUT,
    output reg PIN_PORT_OE,
    output reg DIVIDED_CLOCK_OUTPUT
);
    // ---------------------------------------------------------------
    // configuration storage
    // ---------------------------------------------------------------
    reg [7:0] chip_config_reg_zero;
    reg [AW-1:0] cs_base [0:NCS-1];
    reg [AW-1:0] cs_limit [0:NCS-1];
    reg [CFGW-1:0] cs_cfg [0:NCS-1];
    reg port_mode;
    reg port_dir;
    reg port_out;
    reg pending;
    integer i;

    wire high_byte_pin_select_bit;
    assign high_byte_pin_select_bit = chip_config_reg_zero[`HIGH_BYTE_PIN_SELECT_POS];

    // ---------------------------------------------------------------
    // configuration writes
    // ---------------------------------------------------------------
    // config writes; select zero starts on its fixed range
    always @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            chip_config_reg_zero <= `CHIP_CONFIG_REG_ZERO_RESET;
            for (i = 0; i < NCS; i = i + 1)
            begin
                // unprogrammed selects get an empty range (base above limit)
                cs_base[i] <= {AW{1'b1}};
                cs_limit[i] <= {AW{1'b0}};
                cs_cfg[i] <= `BUS_CFG_RESET;
            end
            cs_base[0] <= `CS0_RESET_BASE;
            cs_limit[0] <= `CS0_RESET_LIMIT;
        end
        else
        begin
            if (CHIP_CONFIG_REG_ZERO_WE)
                chip_config_reg_zero <= CHIP_CONFIG_REG_ZERO_WDATA;
            if (CS_WE && (CS_INDEX < NCS))
            begin
                cs_base[CS_INDEX] <= CS_BASE;
                cs_limit[CS_INDEX] <= CS_LIMIT;
                cs_cfg[CS_INDEX] <= CS_BUS_CFG;
            end
        end
    end

    // ---------------------------------------------------------------
    // port registers behind the shared bus request pin
    // ---------------------------------------------------------------
    // writes are dropped, not deferred, while the hold protocol owns the pin
    always @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            port_mode <= 1'b0;
            port_dir <= 1'b0;
            port_out <= 1'b0;
        end
        else if (PORT_WE && !HOLD_PROTOCOL_ENABLE_BIT)
        begin
            port_mode <= PORT_TWO_MODE_REG;
            port_dir <= PORT_TWO_DIRECTION_REG;
            port_out <= PORT_TWO_OUTPUT_REG;
        end
    end

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    wire [NCS-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NCS; g = g + 1)
        begin : g_match
            cs_range_match #(.AW(AW)) u_match
            (
                .addr(CYCLE_ADDR),
                .base(cs_base[g]),
                .limit(cs_limit[g]),
                .hit(hit[g])
            );
        end
    endgenerate

    // partition check uses the live pin level, no latch
    wire in_ea_part;
    wire is_external;
    assign in_ea_part = (CYCLE_ADDR >= `EA_PART_LOW) && (CYCLE_ADDR <= `EA_PART_HIGH);
    assign is_external = in_ea_part ? !EXTERNAL_ACCESS_N : 1'b1;

    // an access that leaves the chip; only these may ask for the bus back
    wire ext_start;
    assign ext_start = CYCLE_START && is_external;

    // lowest select wins when ranges overlap
    reg [NCS-1:0] next_cs_n;
    reg [CFGW-1:0] next_cfg;
    reg found;
    integer k;
    always @*
    begin
        next_cs_n = {NCS{1'b1}};
        next_cfg = cs_cfg[NCS-1];
        found = 1'b0;
        for (k = 0; k < NCS; k = k + 1)
        begin
            if (hit[k] && !found)
            begin
                next_cs_n[k] = 1'b0;
                next_cfg = cs_cfg[k];
                found = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // byte lanes
    // ---------------------------------------------------------------
    // word access: both lanes low; byte access: lane from address bit zero
    wire lane_high_n;
    assign lane_high_n = CYCLE_WORD ? 1'b0 : !CYCLE_ADDR[0];

    // ---------------------------------------------------------------
    // cycle outputs
    // ---------------------------------------------------------------
    // strobes register on the start pulse and hold until the next one
    always @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BYTE_HIGH_ENABLE_N <= 1'b1;
            WRITE_HIGH_STROBE_N <= 1'b1;
            ADDRESS_BIT_ZERO <= 1'b0;
            CHIP_SELECT_LINES_N <= {NCS{1'b1}};
            ACTIVE_BUS_CFG <= `BUS_CFG_RESET;
            EXT_ADDR <= {`EXT_ADDR_W{1'b0}};
            EXTERNAL_CYCLE <= 1'b0;
        end
        else if (CYCLE_START)
        begin
            EXTERNAL_CYCLE <= is_external;
            EXT_ADDR <= CYCLE_ADDR[`EXT_ADDR_W-1:0];
            ADDRESS_BIT_ZERO <= CYCLE_WORD ? 1'b0 : CYCLE_ADDR[0];
            ACTIVE_BUS_CFG <= next_cfg;
            if (is_external)
            begin
                CHIP_SELECT_LINES_N <= next_cs_n;
                if (high_byte_pin_select_bit)
                begin
                    BYTE_HIGH_ENABLE_N <= lane_high_n;
                    WRITE_HIGH_STROBE_N <= 1'b1;
                end
                else
                begin
                    BYTE_HIGH_ENABLE_N <= 1'b1;
                    WRITE_HIGH_STROBE_N <= !(CYCLE_WRITE && !lane_high_n);
                end
            end
            else
            begin
                CHIP_SELECT_LINES_N <= {NCS{1'b1}};
                BYTE_HIGH_ENABLE_N <= 1'b1;
                WRITE_HIGH_STROBE_N <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // bus request and shared pin
    // ---------------------------------------------------------------
    // the pending cycle counts in the same edge it arrives, so the request
    // goes out one cycle after the start rather than two
    wire hold_wants_bus;
    assign hold_wants_bus = HOLD_PROTOCOL_ENABLE_BIT && HOLD_ACTIVE && (pending || ext_start);

    // pending is set by an external start during hold; set beats clear
    always @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pending <= 1'b0;
            BUS_REQUEST_OUT_N <= 1'b1;
        end
        else
        begin
            if (ext_start && HOLD_ACTIVE)
                pending <= 1'b1;
            else if (!HOLD_ACTIVE)
                pending <= 1'b0;
            BUS_REQUEST_OUT_N <= !hold_wants_bus;
        end
    end

    // ---------------------------------------------------------------
    // shared pin ownership
    // ---------------------------------------------------------------
    // a plain port output drives the pin only in mode 0 with direction 0
    wire port_drives;
    assign port_drives = (port_mode == 1'b0) && (port_dir == 1'b0);

    // the hold protocol takes the pin whatever the port registers hold
    always @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PIN_IS_PORT <= 1'b1;
            PIN_PORT_OUT <= 1'b0;
            PIN_PORT_OE <= 1'b0;
        end
        else
        begin
            PIN_IS_PORT <= !HOLD_PROTOCOL_ENABLE_BIT;
            PIN_PORT_OUT <= HOLD_PROTOCOL_ENABLE_BIT ? 1'b0 : port_out;
            PIN_PORT_OE <= HOLD_PROTOCOL_ENABLE_BIT ? 1'b0 : port_drives;
        end
    end

    // ---------------------------------------------------------------
    // divided clock
    // ---------------------------------------------------------------
    // toggle flop gives exactly half rate and even duty
    always @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            DIVIDED_CLOCK_OUTPUT <= 1'b0;
        else
            DIVIDED_CLOCK_OUTPUT <= !DIVIDED_CLOCK_OUTPUT;
    end
endmodule

//--- tb/ext_bus_monitor.sv
// port-level checker for the external bus select and strobe block
// assumes one clock CLOCK and asynchronous active-low RST_N
module ext_bus_monitor
#(
    parameter NCS = 6,
    parameter AW = 24
)
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CYCLE_START,
    input wire logic [AW-1:0] CYCLE_ADDR,
    input wire logic EXTERNAL_ACCESS_N,
    input wire logic HOLD_PROTOCOL_ENABLE_BIT,
    input wire logic HOLD_ACTIVE,
    input wire logic BYTE_HIGH_ENABLE_N,
    input wire logic WRITE_HIGH_STROBE_N,
    input wire logic [NCS-1:0] CHIP_SELECT_LINES_N,
    input wire logic [19:0] EXT_ADDR,
    input wire logic EXTERNAL_CYCLE,
    input wire logic BUS_REQUEST_OUT_N,
    input wire logic PIN_IS_PORT,
    input wire logic PIN_PORT_OE,
    input wire logic DIVIDED_CLOCK_OUTPUT
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // timing relations at the pins
    // ----------------------------------------
    wire logic in_part = CYCLE_ADDR >= 24'hFF2000 && CYCLE_ADDR <= 24'hFFDFFF;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // the first edge out of reset has no earlier toggle to compare against
    AST_CLK_HALF: assert property ($past(RST_N)
        |-> DIVIDED_CLOCK_OUTPUT != $past(DIVIDED_CLOCK_OUTPUT))
        else $error("clock output missed a toggle");
    AST_PIN_LOCK: assert property (HOLD_PROTOCOL_ENABLE_BIT
        |=> !PIN_IS_PORT && !PIN_PORT_OE)
        else $error("locked pin acted as port");
    AST_BUS_REQUEST_OUT_N_IDLE: assert property (!(HOLD_ACTIVE && HOLD_PROTOCOL_ENABLE_BIT)
        |=> BUS_REQUEST_OUT_N)
        else $error("bus request outside hold");
    AST_BUS_REQUEST_OUT_N_ASK: assert property (HOLD_PROTOCOL_ENABLE_BIT && HOLD_ACTIVE && CYCLE_START
        && !(in_part && EXTERNAL_ACCESS_N) |=> !BUS_REQUEST_OUT_N)
        else $error("no bus request for pending cycle");
    AST_CS_ONE: assert property ($onehot0(~CHIP_SELECT_LINES_N))
        else $error("several selects low");
    AST_CS_EXT: assert property (!(&CHIP_SELECT_LINES_N) |-> EXTERNAL_CYCLE)
        else $error("select low on internal cycle");
    AST_INTERNAL: assert property (CYCLE_START && in_part && EXTERNAL_ACCESS_N
        |=> !EXTERNAL_CYCLE && &CHIP_SELECT_LINES_N)
        else $error("partition access left the chip");
    AST_EA_LIVE: assert property (CYCLE_START && in_part && !EXTERNAL_ACCESS_N
        |=> EXTERNAL_CYCLE)
        else $error("live external access ignored");
    AST_EXT_ADDR: assert property (CYCLE_START |=> EXT_ADDR == $past(CYCLE_ADDR[19:0]))
        else $error("external address wrong");
    AST_ONE_FUNC: assert property (!WRITE_HIGH_STROBE_N |-> BYTE_HIGH_ENABLE_N)
        else $error("both shared pin functions active");
    C_BUS_REQUEST_OUT_N: cover property (!BUS_REQUEST_OUT_N);
    C_WRH: cover property (!WRITE_HIGH_STROBE_N);
    C_CS0: cover property (!CHIP_SELECT_LINES_N[0]);
endmodule
bind ext_bus_strobes ext_bus_monitor #(.NCS(NCS), .AW(AW)) u_mon (.CLOCK(CLOCK), .RST_N(RST_N),
    .CYCLE_START(CYCLE_START), .CYCLE_ADDR(CYCLE_ADDR), .EXTERNAL_ACCESS_N(EXTERNAL_ACCESS_N),
    .HOLD_PROTOCOL_ENABLE_BIT(HOLD_PROTOCOL_ENABLE_BIT), .HOLD_ACTIVE(HOLD_ACTIVE),
    .BYTE_HIGH_ENABLE_N(BYTE_HIGH_ENABLE_N), .WRITE_HIGH_STROBE_N(WRITE_HIGH_STROBE_N),
    .CHIP_SELECT_LINES_N(CHIP_SELECT_LINES_N), .EXT_ADDR(EXT_ADDR),
    .EXTERNAL_CYCLE(EXTERNAL_CYCLE), .BUS_REQUEST_OUT_N(BUS_REQUEST_OUT_N),
    .PIN_IS_PORT(PIN_IS_PORT), .PIN_PORT_OE(PIN_PORT_OE),
    .DIVIDED_CLOCK_OUTPUT(DIVIDED_CLOCK_OUTPUT));

//--- tb/ext_mem_model.sv
// far-side memory: reports which byte lanes a cycle moves
// assumes it is selected only while an external cycle is shown
module ext_mem_model
(
    input wire logic byte_high_enable_n,
    input wire logic address_bit_zero,
    input wire logic selected,
    output logic [1:0] lanes
);
    timeunit 1ns;
    timeprecision 1ns;
    // lanes {high, low}; a deselected part moves nothing
    always_comb lanes = selected ? {!byte_high_enable_n, !address_bit_zero} : 2'h0;
endmodule

//--- tb/tb_ext_bus_strobes.sv
// self-checking bench for the external bus select and strobe block
// assumes the block's result shows at the edge that samples the start
module tb_ext_bus_strobes;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [23:0] a; logic [5:0] cs; logic [7:0] cfg;
        logic ext, wrh; logic [1:0] ln;} note_t;
    logic clock = 0, rst_n = 0, cycle_start = 0, cycle_write = 0, cycle_word = 0;
    logic external_access_n = 1, ccr_we = 0, cs_we = 0, hold_en = 0, hold_active = 0;
    logic port_we = 0, port_mode = 0, port_dir = 0, port_out = 0, bhe_mode = 1;
    logic [23:0] cycle_addr = 0, cs_base = 0, cs_limit = 0;
    logic [7:0] ccr_wdata = 0, cs_bus_cfg = 0;
    logic [2:0] cs_index = 0;
    logic byte_high_enable_n, write_high_strobe_n, address_bit_zero, external_cycle;
    logic bus_request_out_n, pin_is_port, pin_port_out, pin_port_oe;
    logic [19:0] ext_addr;
    logic [5:0] chip_select_lines_n;
    logic [7:0] active_bus_cfg;
    logic [1:0] lanes;
    logic [23:0] base [6], lim [6];
    logic [7:0] bcfg [6];
    note_t q [$];
    int seed = 16, fails = 0, check_count = 0, k, r;
    ext_bus_strobes u_dut (.CLOCK(clock), .RST_N(rst_n), .CYCLE_START(cycle_start),
        .CYCLE_WRITE(cycle_write), .CYCLE_WORD(cycle_word), .CYCLE_ADDR(cycle_addr),
        .EXTERNAL_ACCESS_N(external_access_n), .CHIP_CONFIG_REG_ZERO_WE(ccr_we), .CHIP_CONFIG_REG_ZERO_WDATA(ccr_wdata),
        .CS_WE(cs_we), .CS_INDEX(cs_index), .CS_BASE(cs_base), .CS_LIMIT(cs_limit),
        .CS_BUS_CFG(cs_bus_cfg), .HOLD_PROTOCOL_ENABLE_BIT(hold_en), .HOLD_ACTIVE(hold_active),
        .PORT_WE(port_we), .PORT_TWO_MODE_REG(port_mode), .PORT_TWO_DIRECTION_REG(port_dir),
        .PORT_TWO_OUTPUT_REG(port_out), .BYTE_HIGH_ENABLE_N(byte_high_enable_n),
        .WRITE_HIGH_STROBE_N(write_high_strobe_n), .ADDRESS_BIT_ZERO(address_bit_zero),
        .CHIP_SELECT_LINES_N(chip_select_lines_n), .ACTIVE_BUS_CFG(active_bus_cfg),
        .EXT_ADDR(ext_addr),
        .EXTERNAL_CYCLE(external_cycle), .BUS_REQUEST_OUT_N(bus_request_out_n),
        .PIN_IS_PORT(pin_is_port), .PIN_PORT_OUT(pin_port_out), .PIN_PORT_OE(pin_port_oe),
        .DIVIDED_CLOCK_OUTPUT());
    ext_mem_model u_mem (.byte_high_enable_n(byte_high_enable_n),
        .address_bit_zero(address_bit_zero), .selected(external_cycle), .lanes(lanes));
    // ----------------------------------------
    // drivers, expectations and compares
    // ----------------------------------------
    initial forever #5 clock = ~clock;
    task automatic summarize;
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t pin level %b", $time, got);
        end
    endtask
    task automatic check_access(input note_t n);
        check_count++;
        if (chip_select_lines_n !== n.cs || external_cycle !== n.ext || lanes !== n.ln
            || ext_addr !== n.a[19:0]
            || write_high_strobe_n !== n.wrh || (n.ext && active_bus_cfg !== n.cfg))
        begin
            fails++;
            $display("BAD %0t access %h", $time, n.a);
        end
    endtask
    // one access; start stays up so calls run back to back, idle drops it
    task automatic access(input logic [23:0] a, input logic wd, wr, ea);
        note_t n;
        n.a = a;
        n.ext = !(a >= 24'hFF2000 && a <= 24'hFFDFFF && ea);
        n.cs = 6'h3F;
        n.cfg = bcfg[5];
        for (int i = 5; i >= 0; i--)
            if (n.ext && a >= base[i] && a <= lim[i])
            begin
                n.cs = ~(6'h01 << i);
                n.cfg = bcfg[i];
            end
        n.ln = n.ext ? {bhe_mode && (wd || a[0]), !a[0]} : 2'h0;
        n.wrh = !(n.ext && !bhe_mode && wr && (wd || a[0]));
        q.push_back(n);
        cycle_start <= 1;
        cycle_addr <= a;
        cycle_word <= wd;
        cycle_write <= wr;
        external_access_n <= ea;
        @(posedge clock);
    endtask
    task automatic idle;
        cycle_start <= 0;
        @(posedge clock);
    endtask
    task automatic set_range(input logic [2:0] i, input logic [23:0] b, l, input logic [7:0] c);
        cs_we <= 1;
        {cs_index, cs_base, cs_limit, cs_bus_cfg} <= {i, b, l, c};
        @(posedge clock);
        cs_we <= 0;
        if (i < 6)
            {base[i], lim[i], bcfg[i]} = {b, l, c};
        @(posedge clock);
    endtask
    // watcher: oldest note against the pins just after the edge that takes the start
    always @(posedge clock)
    begin
        if (cycle_start)
        begin
            #1;
            check_access(q.pop_front());
        end
    end
    // watchdog so a stuck run still reaches the verdict
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("BAD %0t timeout", $time);
        summarize;
    end
    initial
    begin
        for (k = 0; k < 6; k++)
            {base[k], lim[k], bcfg[k]} = {24'hFFFFFF, 24'h0, 8'h00};
        {base[0], lim[0]} = {24'hFF2000, 24'hFF20FF};
        repeat (12) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        // reset range edges, just outside, and external access switched live
        access(24'hFF2000, 1, 0, 0);
        access(24'hFF20FF, 0, 1, 0);
        access(24'hFF2100, 0, 0, 0);
        access(24'hFF2000, 1, 1, 1);
        access(24'hFFE001, 0, 1, 1);
        idle;
        set_range(1, 24'h010000, 24'h01FFFF, 8'h21);
        set_range(2, 24'h018000, 24'h02FFFF, 8'h33);
        set_range(5, 24'hFFFFFF, 24'h000000, 8'h5A);
        set_range(6, 24'h000000, 24'hFFFFFF, 8'hEE);
        // random traffic in both shared pin modes; overlap goes to the lower select
        for (k = 0; k < 40; k++)
        begin
            if (k % 20 == 0)
            begin
                bhe_mode = k == 0 ? 1'b0 : 1'b1;
                ccr_we <= 1;
                ccr_wdata <= {5'h00, bhe_mode, 2'h0};
                idle;
                ccr_we <= 0;
                @(posedge clock);
            end
            r = $random(seed);
            access({6'h00, r[17:1], r[0] & ~r[20]}, r[20], r[21], r[22]);
        end
        idle;
        // port write taken, then refused while the pin is locked
        port_we <= 1;
        port_out <= 1;
        @(posedge clock);
        port_we <= 0;
        hold_en <= 1;
        @(posedge clock);
        port_we <= 1;
        port_out <= 0;
        @(posedge clock);
        port_we <= 0;
        hold_en <= 0;
        @(negedge clock) check_bit(pin_is_port, 0);
        check_bit(pin_port_oe, 0);
        @(negedge clock) check_bit(pin_port_out, 1);
        check_bit(pin_port_oe, 1);
        // bus request while held with an external cycle waiting
        @(posedge clock);
        hold_en <= 1;
        hold_active <= 1;
        access(24'h010000, 1, 0, 1);
        idle;
        @(negedge clock) check_bit(bus_request_out_n, 0);
        @(posedge clock);
        hold_active <= 0;
        @(posedge clock);
        @(negedge clock) check_bit(bus_request_out_n, 1);
        repeat (3) @(posedge clock);
        if (q.size() != 0)
        begin
            fails++;
            $display("BAD %0t notes left %0d", $time, q.size());
        end
        summarize;
    end
endmodule
